// [rtl/dc_offset_consts.vh]
// Purpose: Constants for the dc offset loop control block
// Assumes: APB byte address is four times the register index
// Notes:   Included by the estimator and top-level design files of the block
//
// Function
// - Hold set: freeze estimate, keep applying it
// - Hold clear: estimate keeps refining from samples
// - Span code 0000 gives 1M, doubling to 2G
// - Low-speed only when setting equals 11
// - Reset clears all three configuration registers
// - Correction runs only while dc-cancel enabled
// - Converge to mid-code plus signed 6-bit shift
// - Digital path disabled bypasses offset correction
`ifndef DC_OFFSET_CONSTS_VH
`define DC_OFFSET_CONSTS_VH

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define LOOP_CTRL_INDEX 8'hCF
`define SPEED_CTRL_INDEX 8'hDF
`define PATH_CTRL_INDEX 8'hE0
`define STATUS_INDEX 8'hE1

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define REG_RESET 8'h00
`define LOOP_CTRL_WMASK 8'hBC
`define SPEED_CTRL_WMASK 8'h03
`define HOLD_BIT 7
`define SPAN_MSB 5
`define SPAN_LSB 2
`define LOW_SPEED_ON 2'h3
`define CANCEL_BIT 0
`define PATH_BIT 1
`define SHIFT_MSB 13
`define SHIFT_LSB 8
`define SHIFT_RESET 6'h00

// ----------------------------------------
// Loop averaging span: 2^(BASE + code) cycles
// ----------------------------------------
`define SPAN_BASE 6'h14
`define SPAN_MAX_CODE 4'hB

`endif

// [rtl/offset_estimator.v]
// Purpose: Accumulating dc offset estimator
// Assumes: One error sample per clock
// Notes:   Estimate is accumulator scaled by 2^-(20+code)
`timescale 1ns/1ps
`include "dc_offset_consts.vh"

module offset_estimator #(
    parameter EW = 17,
    parameter AW = 50
) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Control
    input wire run,
    input wire hold,
    input wire [3:0] span_code,
    // Data
    input wire signed [EW-1:0] err,
    output reg signed [EW-1:0] estimate_q
);

reg signed [AW-1:0] acc_q;
reg signed [AW-1:0] acc_d;
reg [3:0] code_eff;
reg [5:0] shift;
reg signed [AW-1:0] scaled;

always @* begin
    // Codes past the longest span act as the longest span
    if (span_code > `SPAN_MAX_CODE) begin
        code_eff = `SPAN_MAX_CODE;
    end else begin
        code_eff = span_code;
    end
    shift = `SPAN_BASE + {2'b00, code_eff};
    scaled = acc_q >>> shift;
    if (!run) begin
        acc_d = {AW{1'b0}};
    end else if (hold) begin
        acc_d = acc_q;
    end else begin
        acc_d = acc_q + {{(AW-EW){err[EW-1]}}, err};
    end
end

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        acc_q <= {AW{1'b0}};
        estimate_q <= {EW{1'b0}};
    end else begin
        acc_q <= acc_d;
        if (!run) begin
            estimate_q <= {EW{1'b0}};
        end else if (!hold) begin
            estimate_q <= scaled[EW-1:0];
        end
    end
end

endmodule // offset_estimator

// [rtl/correction_stage.v]
// Purpose: Applies the offset estimate to each sample
// Assumes: Offset-binary samples, W bits
// Notes:   Result saturates to the code range
`timescale 1ns/1ps

module correction_stage #(
    parameter W = 14,
    parameter EW = 17
) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Control
    input wire apply,
    // Data
    input wire [W-1:0] sample,
    input wire signed [EW-1:0] estimate,
    output reg [W-1:0] out_q
);

function [W-1:0] saturate;
    input signed [EW-1:0] v;
    begin
        if (v < 0) begin
            saturate = {W{1'b0}};
        end else if (v > $signed({{(EW-W){1'b0}}, {W{1'b1}}})) begin
            saturate = {W{1'b1}};
        end else begin
            saturate = v[W-1:0];
        end
    end
endfunction

wire signed [EW-1:0] diff;
assign diff = $signed({{(EW-W){1'b0}}, sample}) - estimate;

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        out_q <= {W{1'b0}};
    end else if (apply) begin
        out_q <= saturate(diff);
    end else begin
        out_q <= sample;
    end
end

endmodule // correction_stage

// [rtl/dc_offset_loop_control.v]
// Purpose: Dc offset correction loop with APB configuration
// Assumes: One sample per clk_sys edge, offset-binary code
// Notes:   Zero-wait APB slave, answer in first access cycle
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "dc_offset_consts.vh"

module dc_offset_loop_control #(
    parameter W = 14
) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Sample stream
    input wire [W-1:0] sample_in,
    output wire [W-1:0] sample_out,
    // Mode outputs
    output reg low_speed_mode,
    output reg correction_active,
    output reg estimate_frozen
);

localparam EW = W + 3;
localparam AW = EW + 33;

// ----------------------------------------
// Address decode helpers
// ----------------------------------------
function hits;
    input [11:0] a;
    input [7:0] idx;
    begin
        hits = (a == {2'b00, idx, 2'b00});
    end
endfunction

function mapped;
    input [11:0] a;
    begin
        mapped = hits(a, `LOOP_CTRL_INDEX) |
            hits(a, `SPEED_CTRL_INDEX) |
            hits(a, `PATH_CTRL_INDEX) |
            hits(a, `STATUS_INDEX);
    end
endfunction

// ----------------------------------------
// Configuration state
// ----------------------------------------
reg [7:0] loop_ctrl_q;
reg [7:0] speed_ctrl_q;
reg cancel_en_q;
reg path_en_q;
reg [5:0] shift_q;
reg [W-1:0] sample_q;

wire setup_phase;
wire access_wr;
wire signed [EW-1:0] estimate;
wire run;
wire hold;
wire [3:0] span_code;

assign setup_phase = psel & ~penable;
// Write lands only on the edge where pready is seen high
assign access_wr = psel & penable & pready & pwrite & ~pslverr;

// ----------------------------------------
// Register writes
// ----------------------------------------
always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        loop_ctrl_q <= `REG_RESET;
        speed_ctrl_q <= `REG_RESET;
        cancel_en_q <= 1'b0;
        path_en_q <= 1'b0;
        shift_q <= `SHIFT_RESET;
    end else if (access_wr) begin
        // Reserved bits are dropped, so they always read zero
        if (hits(paddr, `LOOP_CTRL_INDEX)) begin
            loop_ctrl_q <= pwdata[7:0] & `LOOP_CTRL_WMASK;
        end
        if (hits(paddr, `SPEED_CTRL_INDEX)) begin
            speed_ctrl_q <= pwdata[7:0] & `SPEED_CTRL_WMASK;
        end
        if (hits(paddr, `PATH_CTRL_INDEX)) begin
            cancel_en_q <= pwdata[`CANCEL_BIT];
            path_en_q <= pwdata[`PATH_BIT];
            shift_q <= pwdata[`SHIFT_MSB:`SHIFT_LSB];
        end
    end
end

// ----------------------------------------
// APB answer
// ----------------------------------------
reg [31:0] rd_word;

always @* begin
    rd_word = 32'h00000000;
    if (hits(paddr, `LOOP_CTRL_INDEX)) begin
        rd_word[7:0] = loop_ctrl_q;
    end
    if (hits(paddr, `SPEED_CTRL_INDEX)) begin
        rd_word[7:0] = speed_ctrl_q;
    end
    if (hits(paddr, `PATH_CTRL_INDEX)) begin
        rd_word[`CANCEL_BIT] = cancel_en_q;
        rd_word[`PATH_BIT] = path_en_q;
        rd_word[`SHIFT_MSB:`SHIFT_LSB] = shift_q;
    end
    if (hits(paddr, `STATUS_INDEX)) begin
        rd_word[0] = low_speed_mode;
        rd_word[1] = correction_active;
        rd_word[2] = estimate_frozen;
        // Only the low 16 estimate bits fit the word
        rd_word[31:16] = estimate[15:0];
    end
end

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (setup_phase) begin
        // Answer prepared in setup so every APB output is a flop
        pready <= 1'b1;
        pslverr <= ~mapped(paddr);
        if (!pwrite) begin
            prdata <= rd_word;
        end else begin
            prdata <= 32'h00000000;
        end
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

// ----------------------------------------
// Loop control decode
// ----------------------------------------
// Hold has no effect unless cancel enable and path enable are both set
assign run = cancel_en_q & path_en_q;
assign hold = loop_ctrl_q[`HOLD_BIT];
assign span_code = loop_ctrl_q[`SPAN_MSB:`SPAN_LSB];

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        low_speed_mode <= 1'b0;
        correction_active <= 1'b0;
        estimate_frozen <= 1'b0;
    end else begin
        low_speed_mode <= (speed_ctrl_q[1:0] == `LOW_SPEED_ON);
        correction_active <= run;
        estimate_frozen <= run & hold;
    end
end

// ----------------------------------------
// Loop error: corrected sample minus settle target
// ----------------------------------------
wire signed [EW-1:0] mid_code;
wire signed [EW-1:0] target;
wire signed [EW-1:0] corrected;
wire signed [EW-1:0] err;

assign mid_code = $signed({{(EW-W){1'b0}}, 1'b1, {(W-1){1'b0}}});
assign target = mid_code + {{(EW-6){shift_q[5]}}, shift_q};
assign corrected = $signed({{(EW-W){1'b0}}, sample_q}) - estimate;
// Unsaturated value keeps the loop linear near the rails
assign err = corrected - target;

always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
        sample_q <= {W{1'b0}};
    end else begin
        sample_q <= sample_in;
    end
end

// ----------------------------------------
// Estimator and correction
// ----------------------------------------
offset_estimator #(
    .EW(EW),
    .AW(AW)
) u_est (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(run),
    .hold(hold),
    .span_code(span_code),
    .err(err),
    .estimate_q(estimate)
);

correction_stage #(
    .W(W),
    .EW(EW)
) u_corr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .apply(run),
    .sample(sample_q),
    .estimate(estimate),
    .out_q(sample_out)
);

endmodule // dc_offset_loop_control

// [tb/dc_offset_loop_props.sv]
// Purpose: Port checks for dc_offset_loop_control
// Assumes: Zero-wait APB; mode outputs lag writes by one edge
// Notes:   Attached by the bind below the module
`timescale 1ns/1ps
module dc_offset_loop_props #(parameter W = 14) (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Samples and modes
    input wire [W-1:0] sample_in,
    input wire [W-1:0] sample_out,
    input wire low_speed_mode,
    input wire correction_active,
    input wire estimate_frozen
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    wire mapped = paddr == 12'h33C || paddr == 12'h37C
        || paddr == 12'h380 || paddr == 12'h384;
    wire path_wr = psel && penable && pready && pwrite && paddr == 12'h380;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_speed_wr;
        psel && penable && pready ##0 pwrite && paddr == 12'h37C;
    endsequence
    property p_ready_access;
        s_setup |=> psel && penable && pready;
    endproperty
    a_ready_access: assert property (p_ready_access)
        else $error("ready missing in access cycle");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse)
        else $error("ready held too long");
    property p_err_map;
        pready |-> pslverr == !mapped;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("error flag wrong for address");
    property p_reset_clear;
        disable iff (1'b0)
        !nrst |-> !(low_speed_mode || correction_active || estimate_frozen);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("mode output set in reset");
    property p_low_speed;
        s_speed_wr |-> ##2 low_speed_mode == ($past(pwdata[1:0], 2) == 2'h3);
    endproperty
    a_low_speed: assert property (p_low_speed)
        else $error("low speed mode wrong");
    property p_frozen_active;
        estimate_frozen |-> correction_active;
    endproperty
    a_frozen_active: assert property (p_frozen_active)
        else $error("frozen while inactive");
    property p_active_cause;
        !$stable(correction_active) |-> $past(path_wr, 2);
    endproperty
    a_active_cause: assert property (p_active_cause)
        else $error("active changed without write");
    property p_bypass;
        !correction_active && !$past(correction_active)
            && !$past(correction_active, 2)
            |-> sample_out == $past(sample_in, 2);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("sample not passed through");
    property p_hold_const;
        estimate_frozen [*4] ##0 $past(sample_in, 2) == $past(sample_in, 3)
            |-> $stable(sample_out);
    endproperty
    a_hold_const: assert property (p_hold_const)
        else $error("output moved while frozen");
endmodule // dc_offset_loop_props

bind dc_offset_loop_control dc_offset_loop_props #(.W(W)) u_props (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
    .sample_out(sample_out), .low_speed_mode(low_speed_mode),
    .correction_active(correction_active),
    .estimate_frozen(estimate_frozen)
);

// [tb/test_dc_offset_loop_control.sv]
// Purpose: Self-checking bench for dc_offset_loop_control
// Assumes: Zero-wait APB slave, 200 MHz clock
// Notes:   Loop growth is sampled, never run to convergence
`timescale 1ns/1ps
`include "dc_offset_consts.vh"
module test_dc_offset_loop_control;
    localparam [11:0] A_LOOP = {`LOOP_CTRL_INDEX, 2'b00};
    localparam [11:0] A_SPEED = {`SPEED_CTRL_INDEX, 2'b00};
    localparam [11:0] A_PATH = {`PATH_CTRL_INDEX, 2'b00};
    localparam [11:0] A_STAT = {`STATUS_INDEX, 2'b00};
    reg clk_sys, nrst, psel, penable, pwrite, err;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg [13:0] sample_in;
    reg [15:0] e1;
    wire [31:0] prdata;
    wire [13:0] sample_out;
    wire pready, pslverr, low_speed_mode, correction_active, estimate_frozen;
    integer err_total, checks, m;
    dc_offset_loop_control #(.W(14)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_in(sample_in),
        .sample_out(sample_out), .low_speed_mode(low_speed_mode),
        .correction_active(correction_active),
        .estimate_frozen(estimate_frozen)
    );
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ----------------
    // Shared tasks
    // ----------------
    task report_and_stop;
        begin
            if (err_total == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Idle edge after release, so calls never collide in one step
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            n = 0;
            @(posedge clk_sys);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge clk_sys);
            end
            if (n == 50) begin
                err_total = err_total + 1;
                report_and_stop;
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task t_reset;
        begin
            apb(1'b0, A_LOOP, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, A_SPEED, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, A_STAT, 32'h0);
            check(rd, 32'h0);
        end
    endtask
    task t_fields;
        begin
            apb(1'b1, A_LOOP, 32'hAC);
            apb(1'b0, A_LOOP, 32'h0);
            check(rd, 32'hAC);
            apb(1'b1, A_LOOP, 32'h0);
            apb(1'b1, 12'h200, 32'h1);
            check({31'h0, err}, 32'h1);
            apb(1'b0, 12'h200, 32'h0);
            check({31'h0, err}, 32'h1);
            check(rd, 32'h0);
        end
    endtask
    task t_speed;
        begin
            for (m = 0; m < 4; m = m + 1) begin
                apb(1'b1, A_SPEED, m);
                apb(1'b0, A_SPEED, 32'h0);
                check(rd, m);
                check(low_speed_mode, m == 3);
            end
            apb(1'b1, A_SPEED, 32'h0);
        end
    endtask
    task t_bypass;
        begin
            for (m = 0; m < 4; m = m + 1) begin
                apb(1'b1, A_PATH, m);
                sample_in <= 14'h1230 ^ m[13:0];
                repeat (4) @(posedge clk_sys);
                check(correction_active, m == 3);
                if (m < 3)
                    check(sample_out, sample_in);
            end
        end
    endtask
    task t_loop;
        begin
            sample_in <= 14'h2400;
            repeat (3000) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            check(rd[31:16] == 16'h0, 1'b0);
            apb(1'b1, A_LOOP, 32'h80);
            repeat (8) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            e1 = rd[31:16];
            check(estimate_frozen, 1'b1);
            repeat (500) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            check(rd[31:16], e1);
            check(sample_out, sample_in - e1[13:0]);
            apb(1'b1, A_LOOP, 32'h0);
            repeat (3000) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            check(rd[31:16] == e1, 1'b0);
        end
    endtask
    // Sample sitting on the shifted target gives zero error
    task t_shift;
        begin
            apb(1'b1, A_PATH, 32'h0);
            sample_in <= 14'h201F;
            apb(1'b1, A_PATH, 32'h1F03);
            repeat (3000) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            check(rd, 32'h2);
            check(sample_out, 32'h201F);
            apb(1'b1, A_PATH, 32'h0);
            sample_in <= 14'h1FE0;
            apb(1'b1, A_PATH, 32'h2003);
            repeat (3000) @(posedge clk_sys);
            apb(1'b0, A_STAT, 32'h0);
            check(rd, 32'h2);
            check(sample_out, 32'h1FE0);
        end
    endtask
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        sample_in = 14'h0000;
        err_total = 0;
        checks = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_reset;
        t_fields;
        t_speed;
        t_bypass;
        t_loop;
        t_shift;
        report_and_stop;
    end
endmodule // test_dc_offset_loop_control
